// *** dwl_pkg.sv ***
// Shared constants, types and helper functions for the write-leveling timing link.
package dwl_pkg;
	// Clock rates and the divider that makes the link clock.
	localparam int REF_PERIOD_PS = 8000;
	localparam int CK_DIV = 2;
	localparam int CK_PERIOD_PS = REF_PERIOD_PS * CK_DIV;

	// Rounds a time in ns up to whole link clock cycles.
	function automatic int ns_to_ck(input int ns);
		return (ns * 1000 + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
	endfunction

	// Controller-side timing counts, in link clock cycles except the two given in ns.
	localparam int WL_ENABLE_TO_FIRST_STROBE = 40;
	localparam int WL_ENABLE_TO_STROBE_DRIVE = 25;
	localparam int MODE_REG_DELAY = 4;
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int WRITE_RECOVERY_CK = ns_to_ck(WRITE_RECOVERY_TIME_NS);
	localparam int REFRESH_TO_POWERDOWN = 1;
	localparam int POWERDOWN_EXIT_LOCKED_LOOP_NS = 24;
	localparam int POWERDOWN_EXIT_LOCKED_LOOP_MIN = 10;
	localparam int PD_LOCKED_CK = ns_to_ck(POWERDOWN_EXIT_LOCKED_LOOP_NS);
	localparam int POWERDOWN_EXIT_LOCKED_LOOP_CK = (PD_LOCKED_CK > POWERDOWN_EXIT_LOCKED_LOOP_MIN) ?
		PD_LOCKED_CK : POWERDOWN_EXIT_LOCKED_LOOP_MIN;

	// Device-side timing counts, in link clock cycles.
	localparam int ZQ_SHORT_CYCLES = 64;
	localparam int ROW_BUSY_CYCLES = 4;
	localparam int REFRESH_BUSY_CYCLES = 20;
	localparam int BURST_EIGHT_TAIL = 4;
	localparam int BURST_CHOP_FOUR_TAIL = 2;
	localparam int CWL_BASE = 5;
	localparam int WR_PIPE_W = 18;
	localparam int ODT_HIST_W = 16;

	// Link commands.
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_MRS = 3'h1,
		CMD_ACT = 3'h2,
		CMD_PRE = 3'h3,
		CMD_REF = 3'h4,
		CMD_WR = 3'h5,
		CMD_ZQCS = 3'h6
	} dwl_cmd_t;

	// Mode register fields, selected by bank address.
	localparam logic [2:0] BA_MODE_REG_ZERO = 3'h0;
	localparam logic [2:0] BA_MODE_REG_ONE = 3'h1;
	localparam logic [2:0] BA_MODE_REG_TWO = 3'h2;
	localparam int MR0_BURST_LSB = 0;
	localparam int MR0_WR_LSB = 9;
	localparam int MR1_WL_BIT = 7;
	localparam int MR2_CWL_LSB = 3;
	localparam int MR2_WRTERM_LSB = 9;
	localparam int WR_CHOP_BIT = 12;
	localparam logic [1:0] BURST_OTF = 2'h1;
	localparam logic [1:0] BURST_CHOP_FOUR_FIXED = 2'h2;

	// APB register map.
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_CMD = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam int CTRL_CKE_BIT = 0;
	localparam int CTRL_ODT_BIT = 1;
	localparam int CTRL_STROBE_EN_BIT = 2;
	localparam int CTRL_STROBE_PULSE_BIT = 3;
	localparam int CTRL_DLL_FROZEN_BIT = 4;
	localparam int CTRL_RESET_BIT = 5;
	localparam logic [5:0] CTRL_RESET_VAL = 6'h20;
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_BA_LSB = 4;
	localparam int CMD_ADDR_LSB = 16;
endpackage

// *** dwl_link_if.sv ***
// Interface joining the controller end and the memory device end.
`timescale 1ns/10ps
`default_nettype none
interface dwl_link_if;
	logic ck;
	logic rst;
	logic cke;
	dwl_pkg::dwl_cmd_t cmd;
	logic [2:0] ba;
	logic [15:0] addr;
	logic odt;
	logic dqs;
	logic dqs_oe;
	logic wl_fb;
	logic zq_busy;

	// The controller makes the clock and drives commands and strobes.
	modport ctrl (output ck, rst, cke, cmd, ba, addr, odt, dqs, dqs_oe, input wl_fb, zq_busy);
	// The device follows the link clock and reports feedback and calibration.
	modport sdram (input ck, rst, cke, cmd, ba, addr, odt, dqs, dqs_oe, output wl_fb, zq_busy);
endinterface
`default_nettype wire

// *** dwl_sdram_end.sv ***
// Memory device end: write timing, termination, power-down and calibration.
`timescale 1ns/10ps
`default_nettype none
module dwl_sdram_end (
	// Link from the controller.
	dwl_link_if.sdram link,
	// Device state toward the user side.
	output logic write_start_o,
	output logic nominal_termination_o,
	output logic write_termination_o,
	output logic low_power_o,
	output logic wl_mode_o
);
	logic [1:0] burst_mode_r;
	logic [2:0] cwl_r;
	logic [1:0] wrterm_r;
	logic wl_r;
	logic [4:0] write_latency;
	logic [4:0] wr_delay;
	logic [dwl_pkg::WR_PIPE_W-1:0] wr_pipe_r;
	logic [4:0] wr_win_r;
	logic [dwl_pkg::ODT_HIST_W-1:0] odt_hist_r;
	logic [4:0] term_off_latency;
	logic term_req;
	logic [7:0] busy_r;
	logic cke_r;
	logic [6:0] zq_r;
	logic fb_r;
	logic active;

	// Commands count only while clock enable is high at the same edge.
	assign active = link.cke;
	assign write_latency = 5'(dwl_pkg::CWL_BASE) + {2'h0, cwl_r};
	assign term_off_latency = write_latency - 5'h2;
	// Fixed chop starts the internal write earlier than eight-beat or on-the-fly bursts.
	assign wr_delay = write_latency + ((burst_mode_r == dwl_pkg::BURST_CHOP_FOUR_FIXED) ?
		5'(dwl_pkg::BURST_CHOP_FOUR_TAIL) : 5'(dwl_pkg::BURST_EIGHT_TAIL)); // [R8]
	assign term_req = odt_hist_r[term_off_latency[3:0]];

	// Mode registers written by mode register commands.
	always_ff @(posedge link.ck) begin
		if (link.rst) begin
			burst_mode_r <= 2'h0;
			cwl_r <= 3'h0;
			wrterm_r <= 2'h0;
			wl_r <= 1'b0;
		end else if (active && link.cmd == dwl_pkg::CMD_MRS) begin
			if (link.ba == dwl_pkg::BA_MODE_REG_ZERO) begin
				burst_mode_r <= link.addr[dwl_pkg::MR0_BURST_LSB +: 2];
			end
			if (link.ba == dwl_pkg::BA_MODE_REG_ONE) begin
				wl_r <= link.addr[dwl_pkg::MR1_WL_BIT];
			end
			if (link.ba == dwl_pkg::BA_MODE_REG_TWO) begin
				cwl_r <= link.addr[dwl_pkg::MR2_CWL_LSB +: 3];
				wrterm_r <= link.addr[dwl_pkg::MR2_WRTERM_LSB +: 2];
			end
		end
	end

	// Internal write start pipeline and write window.
	always_ff @(posedge link.ck) begin
		if (link.rst) begin
			wr_pipe_r <= '0;
			wr_win_r <= 5'h0;
		end else begin
			wr_pipe_r <= wr_pipe_r >> 1;
			if (wr_win_r != 5'h0) begin
				wr_win_r <= wr_win_r - 5'h1;
			end
			if (active && link.cmd == dwl_pkg::CMD_WR) begin
				wr_pipe_r[wr_delay - 5'h1] <= 1'b1; // [R8]
				wr_win_r <= wr_delay;
			end
		end
	end
	assign write_start_o = wr_pipe_r[0];

	// Sampled termination request history, used for the turn-off latency.
	always_ff @(posedge link.ck) begin
		if (link.rst) begin
			odt_hist_r <= '0;
		end else begin
			odt_hist_r <= {odt_hist_r[dwl_pkg::ODT_HIST_W-2:0], link.odt};
		end
	end

	// Termination switches half a clock after the reference edge.
	always_ff @(negedge link.ck) begin
		if (link.rst) begin
			nominal_termination_o <= 1'b0;
			write_termination_o <= 1'b0;
		end else begin
			nominal_termination_o <= term_req && (wr_win_r == 5'h0); // [R3] [R4]
			write_termination_o <= term_req && (wr_win_r != 5'h0) && (wrterm_r != 2'h0); // [R3] [R4]
		end
	end

	// Row, precharge and refresh work runs on even after clock enable drops.
	always_ff @(posedge link.ck) begin
		if (link.rst) begin
			busy_r <= 8'h0;
			cke_r <= 1'b0;
			low_power_o <= 1'b0;
		end else begin
			cke_r <= link.cke;
			low_power_o <= !cke_r && (busy_r == 8'h0); // [R9]
			if (active && link.cmd == dwl_pkg::CMD_REF) begin
				busy_r <= 8'(dwl_pkg::REFRESH_BUSY_CYCLES);
			end else if (active && (link.cmd == dwl_pkg::CMD_ACT || link.cmd == dwl_pkg::CMD_PRE)) begin
				busy_r <= 8'(dwl_pkg::ROW_BUSY_CYCLES);
			end else if (busy_r != 8'h0) begin
				busy_r <= busy_r - 8'h1; // [R9]
			end
		end
	end

	// Short calibration occupies a fixed 64-cycle window.
	always_ff @(posedge link.ck) begin
		if (link.rst) begin
			zq_r <= 7'h0;
		end else if (active && link.cmd == dwl_pkg::CMD_ZQCS) begin
			zq_r <= 7'(dwl_pkg::ZQ_SHORT_CYCLES); // [R11]
		end else if (zq_r != 7'h0) begin
			zq_r <= zq_r - 7'h1;
		end
	end
	assign link.zq_busy = (zq_r != 7'h0);

	// Write-leveling feedback: the strobe level sampled at the clock edge.
	always_ff @(posedge link.ck) begin
		if (link.rst) begin
			fb_r <= 1'b0;
		end else begin
			fb_r <= wl_r && link.dqs_oe && link.dqs;
		end
	end
	assign link.wl_fb = fb_r;
	assign wl_mode_o = wl_r;
endmodule // dwl_sdram_end
`default_nettype wire

// *** dwl_ctrl_end.sv ***
// Controller end: APB registers, link clock divider and cycle-timing counters.
// What this block and the device end do
// [R1] Strobe first edge waits 40 cycles after enable.
// [R2] Strobe drive waits 25 cycles after enable.
// [R3] Device drops termination 0.3-0.7 clock after latency.
// [R4] Dynamic termination change skew 0.3-0.7 clock.
// [R5] Cycle timings count real clock edges.
// [R6] Nanosecond times round up to clock cycles.
// [R7] Write recovery cycles go into mode register zero.
// [R8] Internal write starts latency plus four or two.
// [R9] Device accepts power-down while operations finish.
// [R10] Power-down after refresh waits its minimum.
// [R11] Short calibration completes within 64 cycles.
// [R12] Each timing has a down-counter gating commands.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
module dwl_ctrl_end (
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Link to the memory device.
	dwl_link_if.ctrl link
);
	// Maps write recovery cycles to the mode register zero code.
	function automatic logic [2:0] wr_code(input int cyc);
		if (cyc <= 5) begin
			return 3'h1;
		end else if (cyc <= 8) begin
			return 3'(cyc - 4);
		end else if (cyc <= 10) begin
			return 3'h5;
		end else if (cyc <= 12) begin
			return 3'h6;
		end else if (cyc <= 14) begin
			return 3'h7;
		end
		return 3'h0;
	endfunction

	localparam logic [2:0] WR_FIELD = wr_code(dwl_pkg::WRITE_RECOVERY_CK); // [R6] [R7]

	logic ck_r;
	logic tick;
	logic [5:0] ctrl_r;
	logic strobe_req_r;
	logic cmd_pend_r;
	dwl_pkg::dwl_cmd_t cmd_code_r;
	logic [2:0] cmd_ba_r;
	logic [15:0] cmd_addr_r;
	logic [31:0] prdata_r;
	logic [5:0] mrd_cnt_r;
	logic [5:0] first_cnt_r;
	logic [5:0] drive_cnt_r;
	logic [5:0] pd_cnt_r;
	dwl_pkg::dwl_cmd_t link_cmd_r;
	logic [2:0] link_ba_r;
	logic [15:0] link_addr_r;
	logic link_cke_r;
	logic link_odt_r;
	logic link_dqs_r;
	logic link_oe_r;
	logic fb_s1_r;
	logic fb_s2_r;
	logic zq_s1_r;
	logic zq_s2_r;
	logic wr_acc;
	logic rd_setup;
	logic mapped;
	logic issue;
	logic wl_enable_mrs;
	logic [15:0] issue_addr;
	logic link_oe_nxt;

	// APB decode; every access completes with no wait state.
	assign mapped = (paddr_i == dwl_pkg::REG_CTRL) || (paddr_i == dwl_pkg::REG_CMD) ||
		(paddr_i == dwl_pkg::REG_STATUS);
	assign wr_acc = psel_i && penable_i && pwrite_i && mapped;
	assign rd_setup = psel_i && !penable_i && !pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign prdata_o = prdata_r;

	// Link clock divider; tick marks the ref edge on which the link clock falls.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ck_r <= 1'b0;
		end else begin
			ck_r <= !ck_r;
		end
	end
	assign tick = ck_r;

	// Control register, with a self-clearing strobe pulse request.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			ctrl_r <= dwl_pkg::CTRL_RESET_VAL;
		end else if (wr_acc && paddr_i == dwl_pkg::REG_CTRL) begin
			ctrl_r <= pwdata_i[5:0];
		end
	end

	// A pulse request set by software wins over the clear in the same cycle.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			strobe_req_r <= 1'b0;
		end else if (wr_acc && paddr_i == dwl_pkg::REG_CTRL &&
			pwdata_i[dwl_pkg::CTRL_STROBE_PULSE_BIT]) begin
			strobe_req_r <= 1'b1;
		end else if (tick && link_oe_r && link_oe_nxt && first_cnt_r == 6'h0) begin
			strobe_req_r <= 1'b0; // [R1]
		end
	end

	// Command register; a write while a command is pending is ignored.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cmd_pend_r <= 1'b0;
			cmd_code_r <= dwl_pkg::CMD_NOP;
			cmd_ba_r <= 3'h0;
			cmd_addr_r <= 16'h0;
		end else if (wr_acc && paddr_i == dwl_pkg::REG_CMD && !cmd_pend_r) begin
			cmd_pend_r <= 1'b1;
			cmd_code_r <= dwl_pkg::dwl_cmd_t'(pwdata_i[dwl_pkg::CMD_CODE_LSB +: 3]);
			cmd_ba_r <= pwdata_i[dwl_pkg::CMD_BA_LSB +: 3];
			cmd_addr_r <= pwdata_i[dwl_pkg::CMD_ADDR_LSB +: 16];
		end else if (issue) begin
			cmd_pend_r <= 1'b0;
		end
	end

	// A pending command goes out with clock enable high; a mode register write also waits for its counter to run down.
	assign issue = tick && cmd_pend_r && link_cke_r &&
		(cmd_code_r != dwl_pkg::CMD_MRS || mrd_cnt_r == 6'h0); // [R5] [R12]
	assign wl_enable_mrs = issue && cmd_code_r == dwl_pkg::CMD_MRS &&
		cmd_ba_r == dwl_pkg::BA_MODE_REG_ONE && cmd_addr_r[dwl_pkg::MR1_WL_BIT];

	// Strobe drive for the next link cycle; a pulse needs the drive in the cycle before it and in its own cycle.
	assign link_oe_nxt = ctrl_r[dwl_pkg::CTRL_STROBE_EN_BIT] && drive_cnt_r == 6'h0 &&
		!wl_enable_mrs; // [R2]

	// Mode register zero always carries the rounded write recovery code.
	always_comb begin
		issue_addr = cmd_addr_r;
		if (cmd_code_r == dwl_pkg::CMD_MRS && cmd_ba_r == dwl_pkg::BA_MODE_REG_ZERO) begin
			issue_addr[dwl_pkg::MR0_WR_LSB +: 3] = WR_FIELD; // [R7]
		end
	end

	// Down-counters in link clock cycles, one per constraint.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mrd_cnt_r <= 6'h0;
			first_cnt_r <= 6'h0;
			drive_cnt_r <= 6'h0;
			pd_cnt_r <= 6'h0;
		end else if (tick) begin
			if (issue && cmd_code_r == dwl_pkg::CMD_MRS) begin
				mrd_cnt_r <= 6'(dwl_pkg::MODE_REG_DELAY - 1); // [R5]
			end else if (mrd_cnt_r != 6'h0) begin
				mrd_cnt_r <= mrd_cnt_r - 6'h1;
			end
			if (wl_enable_mrs) begin
				first_cnt_r <= 6'(dwl_pkg::WL_ENABLE_TO_FIRST_STROBE - 1); // [R1] [R12]
				drive_cnt_r <= 6'(dwl_pkg::WL_ENABLE_TO_STROBE_DRIVE - 1); // [R2] [R12]
			end else begin
				if (first_cnt_r != 6'h0) begin
					first_cnt_r <= first_cnt_r - 6'h1;
				end
				if (drive_cnt_r != 6'h0) begin
					drive_cnt_r <= drive_cnt_r - 6'h1;
				end
			end
			if (issue && cmd_code_r == dwl_pkg::CMD_REF) begin
				pd_cnt_r <= ctrl_r[dwl_pkg::CTRL_DLL_FROZEN_BIT] ?
					6'(dwl_pkg::POWERDOWN_EXIT_LOCKED_LOOP_CK - 1) :
					6'(dwl_pkg::REFRESH_TO_POWERDOWN - 1); // [R10] [R12]
			end else if (pd_cnt_r != 6'h0) begin
				pd_cnt_r <= pd_cnt_r - 6'h1;
			end
		end
	end

	// Link command, address and bank; a command stands one link cycle.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			link_cmd_r <= dwl_pkg::CMD_NOP;
			link_ba_r <= 3'h0;
			link_addr_r <= 16'h0;
		end else if (tick) begin
			link_cmd_r <= issue ? cmd_code_r : dwl_pkg::CMD_NOP;
			if (issue) begin
				link_ba_r <= cmd_ba_r;
				link_addr_r <= issue_addr;
			end
		end
	end

	// Clock enable, termination request and strobe; clock enable never falls under a command.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			link_cke_r <= 1'b0;
			link_odt_r <= 1'b0;
			link_dqs_r <= 1'b0;
			link_oe_r <= 1'b0;
		end else if (tick) begin
			if (ctrl_r[dwl_pkg::CTRL_CKE_BIT]) begin
				link_cke_r <= 1'b1;
			end else if (pd_cnt_r == 6'h0 && !issue) begin
				link_cke_r <= 1'b0; // [R10]
			end
			link_odt_r <= ctrl_r[dwl_pkg::CTRL_ODT_BIT];
			link_oe_r <= link_oe_nxt; // [R2]
			link_dqs_r <= strobe_req_r && link_oe_r && link_oe_nxt && first_cnt_r == 6'h0; // [R1]
		end
	end

	// Feedback and calibration status cross from the link clock.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			fb_s1_r <= 1'b0;
			fb_s2_r <= 1'b0;
			zq_s1_r <= 1'b0;
			zq_s2_r <= 1'b0;
		end else begin
			fb_s1_r <= link.wl_fb;
			fb_s2_r <= fb_s1_r;
			zq_s1_r <= link.zq_busy;
			zq_s2_r <= zq_s1_r;
		end
	end

	// Read data is captured in the setup cycle.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			prdata_r <= 32'h0;
		end else if (rd_setup) begin
			unique case (paddr_i)
				dwl_pkg::REG_CTRL: prdata_r <= {26'h0, ctrl_r};
				dwl_pkg::REG_CMD: prdata_r <= {cmd_addr_r, 9'h0, cmd_ba_r, 1'b0, cmd_code_r};
				dwl_pkg::REG_STATUS: prdata_r <= {26'h0, pd_cnt_r != 6'h0, first_cnt_r == 6'h0,
					drive_cnt_r == 6'h0, zq_s2_r, fb_s2_r, cmd_pend_r};
				default: prdata_r <= 32'h0;
			endcase
		end
	end

	// Link outputs.
	assign link.ck = ck_r;
	assign link.rst = ctrl_r[dwl_pkg::CTRL_RESET_BIT];
	assign link.cmd = link_cmd_r;
	assign link.ba = link_ba_r;
	assign link.addr = link_addr_r;
	assign link.cke = link_cke_r;
	assign link.odt = link_odt_r;
	assign link.dqs = link_dqs_r;
	assign link.dqs_oe = link_oe_r;
endmodule // dwl_ctrl_end
`default_nettype wire

// *** dwl_link_sva.sv ***
// Concurrent checks on the link between the controller end and the device end.
`timescale 1ns/10ps
`default_nettype none
module dwl_link_sva (
	// Link clock and device reset.
	input wire logic ck,
	input wire logic rst,
	// Commands and strobes from the controller.
	input wire logic cke,
	input wire dwl_pkg::dwl_cmd_t cmd,
	input wire logic [2:0] ba,
	input wire logic [15:0] addr,
	input wire logic odt,
	input wire logic dqs,
	input wire logic dqs_oe,
	// Answers from the device.
	input wire logic wl_fb,
	input wire logic zq_busy
);
	logic [5:0] wl_cnt_r;
	logic wl_seen_r;
	logic wl_on_r;
	logic [2:0] mrs_gap_r;
	logic mrs_seen_r;
	wire mrs_take = cke && (cmd == dwl_pkg::CMD_MRS);

	default clocking cb @(posedge ck); endclocking
	default disable iff (rst);

	// Counts link cycles since the last write to mode register one, saturating.
	always_ff @(posedge ck) begin
		if (rst) begin
			wl_cnt_r <= 6'h00;
			wl_seen_r <= 1'b0;
			wl_on_r <= 1'b0;
		end else if (mrs_take && ba == dwl_pkg::BA_MODE_REG_ONE) begin
			wl_cnt_r <= 6'h01;
			wl_seen_r <= wl_seen_r | addr[dwl_pkg::MR1_WL_BIT];
			wl_on_r <= addr[dwl_pkg::MR1_WL_BIT];
		end else if (wl_cnt_r != 6'h3F) begin
			wl_cnt_r <= wl_cnt_r + 6'h01;
		end
	end

	// Counts link cycles since the last mode register write, saturating.
	always_ff @(posedge ck) begin
		if (rst) begin
			mrs_gap_r <= 3'h0;
			mrs_seen_r <= 1'b0;
		end else if (mrs_take) begin
			mrs_gap_r <= 3'h1;
			mrs_seen_r <= 1'b1;
		end else if (mrs_gap_r != 3'h7) begin
			mrs_gap_r <= mrs_gap_r + 3'h1;
		end
	end

	property p_strobe_drive;
		wl_seen_r && $rose(dqs_oe) |-> wl_cnt_r >= 6'h19;
	endproperty
	a_strobe_drive: assert property (p_strobe_drive) else $error("strobe driven too soon");
	property p_first_strobe;
		wl_on_r && $rose(dqs) |-> wl_cnt_r >= 6'h28;
	endproperty
	a_first_strobe: assert property (p_first_strobe) else $error("first strobe too soon");
	property p_strobe_pulse;
		$rose(dqs) |=> !dqs;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe pulse too long");
	property p_strobe_owned;
		dqs |-> dqs_oe;
	endproperty
	a_strobe_owned: assert property (p_strobe_owned) else $error("strobe high undriven");
	property p_mrs_spacing;
		mrs_take && mrs_seen_r |-> mrs_gap_r >= 3'h4;
	endproperty
	a_mrs_spacing: assert property (p_mrs_spacing) else $error("mode writes too close");
	property p_cmd_cke;
		cmd != dwl_pkg::CMD_NOP |-> cke;
	endproperty
	a_cmd_cke: assert property (p_cmd_cke) else $error("command with clock enable low");
	property p_wl_feedback;
		wl_on_r |=> wl_fb == $past(dqs);
	endproperty
	a_wl_feedback: assert property (p_wl_feedback) else $error("leveling feedback wrong");
	property p_zq_window;
		cke && cmd == dwl_pkg::CMD_ZQCS |-> ##2 zq_busy ##62 zq_busy ##1 !zq_busy;
	endproperty
	a_zq_window: assert property (p_zq_window) else $error("calibration window wrong");
endmodule // dwl_link_sva
`default_nettype wire

// *** ddr3_wl_cycle_timing_rules_tb.sv ***
// Self-checking testbench for the controller and device ends of the write-leveling link.
`timescale 1ns/10ps
`default_nettype none
module ddr3_wl_cycle_timing_rules_tb;
	// One register access: write flag, address, data, expected read data, expected error.
	typedef struct packed {
		logic w;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] exp;
		logic err;
	} dwl_row_t;
	localparam dwl_row_t ROWS [0:4] = '{
		'{1'b0, dwl_pkg::REG_CTRL, 32'h0, 32'h20, 1'b0},
		'{1'b0, 12'h00C, 32'h0, 32'h0, 1'b1},
		'{1'b1, 12'hFFC, 32'hFFFFFFFF, 32'h0, 1'b1},
		'{1'b1, dwl_pkg::REG_CTRL, 32'h1, 32'h0, 1'b0},
		'{1'b0, dwl_pkg::REG_CTRL, 32'h0, 32'h1, 1'b0}};
	localparam logic [31:0] WR_CODE = (dwl_pkg::WRITE_RECOVERY_TIME_NS * 1000
		+ dwl_pkg::CK_PERIOD_PS - 1) / dwl_pkg::CK_PERIOD_PS;
	localparam int CK_NS = dwl_pkg::CK_PERIOD_PS / 1000;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic write_start_o;
	logic nominal_termination_o;
	logic write_termination_o;
	logic low_power_o;
	logic wl_mode_o;
	int err_total = 0;
	int n_tests = 0;
	logic [31:0] rd;
	logic er;
	int n;
	longint t0;

	dwl_link_if link ();
	dwl_ctrl_end i_dwl_ctrl_end (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .link(link));
	dwl_sdram_end i_dwl_sdram_end (.link(link), .write_start_o(write_start_o),
		.nominal_termination_o(nominal_termination_o), .write_termination_o(write_termination_o),
		.low_power_o(low_power_o), .wl_mode_o(wl_mode_o));
	dwl_link_sva i_dwl_link_sva (.ck(link.ck), .rst(link.rst), .cke(link.cke), .cmd(link.cmd),
		.ba(link.ba), .addr(link.addr), .odt(link.odt), .dqs(link.dqs), .dqs_oe(link.dqs_oe),
		.wl_fb(link.wl_fb), .zq_busy(link.zq_busy));

	// System clock, 8 ns period.
	always #4 ref_clk_i = ~ref_clk_i;

	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Compares one value and counts it.
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: %s", $time, msg);
			err_total++;
		end
	endtask

	// A wait that ran out counts as a mismatch and ends the run.
	task automatic timeout(input string msg);
		err_total++;
		$display("CHECK FAILED at %0t: timeout on %s", $time, msg);
		end_sim();
	endtask

	// One link cycle of a bounded wait.
	task automatic step(inout int k, input int lim, input string msg);
		@(posedge link.ck);
		k++;
		if (k > lim) timeout(msg);
	endtask

	// One APB transfer; read data and error are taken at the completing edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
			if (k > 20) timeout("apb");
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Writes a command and waits until the device samples it.
	task automatic send(input logic [31:0] d);
		int k;
		apb(1'b1, dwl_pkg::REG_CMD, d);
		k = 0;
		do step(k, 40, "link command");
		while (!(link.cmd === dwl_pkg::dwl_cmd_t'(d[2:0]) && link.cke === 1'b1));
	endtask

	// Moves the termination request and checks the half-cycle switch point.
	task automatic odt_step(input logic v);
		int k;
		apb(1'b1, dwl_pkg::REG_CTRL, {30'h0, v, 1'b1});
		k = 0;
		do step(k, 20, "odt");
		while (link.odt !== v);
		repeat (dwl_pkg::CWL_BASE - 2) @(posedge link.ck);
		check({31'h0, nominal_termination_o}, {31'h0, ~v}, "termination early");
		@(negedge link.ck);
		#1;
		check({31'h0, nominal_termination_o}, {31'h0, v}, "termination late");
	endtask

	// Main sequence: register table, then the timing cases.
	initial begin
		repeat (3) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
			check({31'h0, er}, {31'h0, ROWS[i].err}, "slave error");
			if (!ROWS[i].w) check(rd, ROWS[i].exp, "read data");
		end
		$display("Register table test done");
		repeat (4) @(posedge link.ck);
		send(32'h0000_0021);
		for (int m = 0; m < 2; m++) begin
			apb(1'b1, dwl_pkg::REG_CMD, {14'h0, m ? dwl_pkg::BURST_CHOP_FOUR_FIXED :
				dwl_pkg::BURST_OTF, 16'h0001});
			n = 0;
			do step(n, 40, "mode write");
			while (link.cmd !== dwl_pkg::CMD_MRS);
			check({29'h0, link.addr[11:9]}, WR_CODE, "write recovery code");
			send(32'h0000_0005);
			n = 0;
			do step(n, 30, "write start");
			while (write_start_o !== 1'b1);
			check(n, dwl_pkg::CWL_BASE + (m ? 2 : 4), "write start edge");
		end
		$display("Write start test done");
		send(32'h0000_0006);
		n = 0;
		repeat (80) begin
			@(posedge link.ck);
			if (link.zq_busy === 1'b1) n++;
		end
		check(n, 64, "calibration busy length");
		$display("Calibration test done");
		send(32'h0080_0011);
		apb(1'b0, dwl_pkg::REG_STATUS, 32'h0);
		check({30'h0, rd[4:3]}, 32'h0, "strobe allowed too soon");
		check({31'h0, wl_mode_o}, 32'h1, "leveling mode");
		n = 0;
		do begin
			apb(1'b0, dwl_pkg::REG_STATUS, 32'h0);
			n++;
			if (n > 100) timeout("first strobe");
		end while (rd[4] !== 1'b1);
		check({31'h0, n > 20}, 32'h1, "first strobe allowed early");
		apb(1'b1, dwl_pkg::REG_CTRL, 32'h0000_000D);
		n = 0;
		do step(n, 20, "leveling feedback");
		while (link.wl_fb !== 1'b1);
		check({31'h0, link.dqs_oe}, 32'h1, "strobe not driven");
		send(32'h0000_0011);
		apb(1'b1, dwl_pkg::REG_CTRL, 32'h1);
		$display("Write leveling test done");
		odt_step(1'b1);
		send(32'h0200_0021);
		send(32'h0000_0005);
		@(negedge link.ck);
		#1;
		check({30'h0, write_termination_o, nominal_termination_o}, 32'h2, "write term late");
		repeat (dwl_pkg::CWL_BASE + dwl_pkg::BURST_CHOP_FOUR_TAIL + 1) @(posedge link.ck);
		check({30'h0, write_termination_o, nominal_termination_o}, 32'h1, "nominal not back");
		odt_step(1'b0);
		$display("Termination test done");
		apb(1'b1, dwl_pkg::REG_CTRL, 32'h11);
		send(32'h0000_0004);
		t0 = $time;
		apb(1'b1, dwl_pkg::REG_CTRL, 32'h10);
		n = 0;
		do step(n, 40, "clock enable low");
		while (link.cke !== 1'b0);
		check({31'h0, ($time - t0) >= 10 * CK_NS}, 32'h1, "power-down too soon");
		check({31'h0, low_power_o}, 32'h0, "low power while refreshing");
		n = 0;
		do step(n, 40, "low power");
		while (low_power_o !== 1'b1);
		check({31'h0, ($time - t0) >= 20 * CK_NS}, 32'h1, "refresh cut short");
		$display("Power-down test done");
		@(posedge ref_clk_i);
		sys_rst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		check({30'h0, link.rst, link.cke}, 32'h2, "link state in reset");
		check(prdata_o, 32'h0, "read data in reset");
		apb(1'b0, dwl_pkg::REG_CTRL, 32'h0);
		check(rd, 32'h20, "control after reset");
		$display("Reset test done");
		end_sim();
	end
endmodule // ddr3_wl_cycle_timing_rules_tb
`default_nettype wire
